// ---- inc/acf_pwm_pkg.sv ----
/*
 types for the switching controller.
 assumes nothing beyond the compiler.
*/
package acf_pwm_pkg;
	typedef enum logic [1:0] {
		amplitude_mod_mode = 2'b00,
		adaptive_burst_state = 2'b01,
		low_power_state = 2'b11,
		standby_state = 2'b10
	} mode_t;
	typedef enum logic [2:0] {
		ph_idle = 3'b000,
		ph_low = 3'b001,
		ph_lh_dead = 3'b011,
		ph_high = 3'b010,
		ph_hl_dead = 3'b110,
		ph_valley = 3'b111
	} phase_t;
endpackage

// ---- inc/acf_pwm_regs.svh ----
/*
 timing constants for the active-clamp flyback switching controller.
 assumes a 100 MHz clock (10 ns period).
*/
`ifndef ACF_PWM_REGS_SVH
`define ACF_PWM_REGS_SVH

`define CLK_PERIOD_NS 10
`define LH_DEAD_FIXED_NS 40
`define LH_DEAD_FIXED_CYC (`LH_DEAD_FIXED_NS / `CLK_PERIOD_NS)
`define ZC_TO_HS_NS 50
`define ZC_TO_HS_CYC (`ZC_TO_HS_NS / `CLK_PERIOD_NS)
`define SETTLE_CYCLES 15
`define LINE_KNEE_UA 666
`define TZ_EXT_PCT 140
`define OPP_TIMEOUT_MS 160
`define OPP_TIMEOUT_CYC (`OPP_TIMEOUT_MS * 100000)
`define BUR_MIN_HZ 20000
`define LPM_BUR_HZ 25000
`define LPM_PERIOD_CYC (100000000 / `LPM_BUR_HZ)
`define BUR_MIN_PERIOD_CYC (100000000 / `BUR_MIN_HZ)
`define NSW_MIN 4'h2
`define NSW_MAX 4'h9
`define TDM_INIT 8'h08
`define TDM_MAX 8'hff

`endif

// ---- sim/acf_power_stage_model.sv ----
/*
 behavioural power stage: peak trip, aux zero cross, zvs comparator.
 assumes registered gate inputs; delays come from the bench's seeded stream.
*/
module acf_power_stage_model (
	input wire logic i_clk,
	input wire logic i_low_on,
	input wire logic i_high_on,
	input wire logic i_zvs_allowed,
	output logic o_trip,
	output logic o_zc,
	output logic o_zvs
);
	timeunit 1ns;
	timeprecision 1ps;
	int lo_n = 0;
	int hi_n = 0;
	int zc_n = 0;
	int trip_at = 3;
	logic lo_d = 1'b0;
	always @(posedge i_clk)
	begin
		lo_d <= i_low_on;
		lo_n <= i_low_on ? lo_n + 1 : 0;
		hi_n <= i_low_on ? 0 : hi_n + int'(i_high_on);
		o_trip <= i_low_on && lo_n == trip_at;
		// ringing delay varies so the valley wait is not a fixed count
		if (lo_d && !i_low_on)
		begin
			zc_n <= $urandom_range(5, 2);
			trip_at <= $urandom_range(6, 2);
		end
		else if (zc_n > 0)
			zc_n <= zc_n - 1;
		o_zc <= zc_n == 1;
		o_zvs <= !i_low_on && !i_high_on && i_zvs_allowed && hi_n > 20;
	end
endmodule

// ---- sim/acf_zvs_mode_pwm_control_asserts.sv ----
/*
 port checks on the switching controller.
 assumes one clock and a synchronous active-high reset.
*/
module acf_pwm_checker #(
	parameter int OPP_TIMEOUT_CYC = 50
)(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_set_select_high,
	input wire logic i_aux_zero_cross_event,
	input wire logic [7:0] i_peak_current_threshold,
	input wire logic [7:0] i_opp_level,
	input wire logic o_low_side_gate_pulse,
	input wire logic o_high_side_gate_pulse,
	input wire logic o_driver_enable,
	input wire logic o_over_power_protection,
	input wire logic [1:0] o_mode,
	input wire logic o_tune_settled
);
	int over_r;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	// run of threshold at or above the limit
	always_ff @(posedge i_clk)
	begin
		if (i_srst || i_peak_current_threshold < i_opp_level)
			over_r <= 0;
		else
			over_r <= over_r + 1;
	end
	sequence s_hs_on;
		$rose(o_high_side_gate_pulse);
	endsequence
	sequence s_fault;
		$rose(o_over_power_protection);
	endsequence
	AST_NO_OVERLAP: assert property (!(o_low_side_gate_pulse && o_high_side_gate_pulse))
		else $error("gates overlap");
	AST_LH_FIXED: assert property (s_hs_on ##0 !i_set_select_high |->
		$past(o_low_side_gate_pulse, 5) && !$past(o_low_side_gate_pulse, 4))
		else $error("fixed dead-time wrong");
	AST_ZC_WAIT: assert property (s_hs_on ##0 i_set_select_high |->
		$past(i_aux_zero_cross_event, 5) || $past(i_aux_zero_cross_event, 6)
		|| $past(i_aux_zero_cross_event, 7))
		else $error("high pulse not after zero cross");
	AST_HS_LOCK: assert property (s_hs_on |-> $past(o_tune_settled))
		else $error("high pulse before lock");
	AST_HS_MODE: assert property (s_hs_on |-> $past(o_mode) inside {2'h0, 2'h1})
		else $error("high pulse in valley mode");
	AST_DRV_AMP: assert property ((o_mode == 2'h0 && !o_over_power_protection)[*4]
		|-> o_driver_enable)
		else $error("driver enable low in amplitude mode");
	AST_MODE_ORDER: assert property (!$past(i_srst) && o_mode != $past(o_mode) |->
		{$past(o_mode), o_mode} inside {4'h1, 4'h7, 4'he, 4'hb, 4'h4, 4'hd})
		else $error("mode skipped");
	AST_FAULT_HOLD: assert property (s_fault |=> o_over_power_protection[*8])
		else $error("fault not sticky");
	AST_FAULT_BLANK: assert property (o_over_power_protection |=>
		!o_low_side_gate_pulse && !o_high_side_gate_pulse && !o_driver_enable)
		else $error("fault did not blank");
	AST_FAULT_EARLY: assert property (s_fault |-> over_r >= OPP_TIMEOUT_CYC - 2)
		else $error("fault too early");
	AST_FAULT_LATE: assert property (over_r > OPP_TIMEOUT_CYC + 3 |->
		o_over_power_protection)
		else $error("fault too late");
endmodule

bind acf_zvs_mode_pwm_control acf_pwm_checker #(.OPP_TIMEOUT_CYC(OPP_TIMEOUT_CYC)) u_chk (
	.i_clk(i_clk), .i_srst(i_srst), .i_set_select_high(i_set_select_high),
	.i_aux_zero_cross_event(i_aux_zero_cross_event),
	.i_peak_current_threshold(i_peak_current_threshold), .i_opp_level(i_opp_level),
	.o_low_side_gate_pulse(o_low_side_gate_pulse),
	.o_high_side_gate_pulse(o_high_side_gate_pulse), .o_driver_enable(o_driver_enable),
	.o_over_power_protection(o_over_power_protection), .o_mode(o_mode),
	.o_tune_settled(o_tune_settled)
);

// ---- sim/acf_zvs_mode_pwm_control_bench.sv ----
/*
 self-checking bench for the switching controller.
 assumes the power stage model beside the design and a fixed seed.
*/
`include "acf_pwm_regs.svh"
module acf_zvs_mode_pwm_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int OPP_CYC = 50;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic sel = 1'b0;
	logic [7:0] tzmin = 8'h03;
	logic [9:0] line = 10'h3ff;
	logic [7:0] thr = 8'h10;
	logic [7:0] lvl = 8'hc0;
	logic dn = 1'b0;
	logic up = 1'b0;
	logic bst = 1'b0;
	logic zvs_ok = 1'b1;
	logic trip, zc, zvs, lo, hi, drv, over_power_protection, lock;
	logic [1:0] mode;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	int g, n, w;
	int lines[4] = '{700, 666, 333, 0};
	acf_zvs_mode_pwm_control #(.OPP_TIMEOUT_CYC(OPP_CYC)) i_dut (.i_clk(i_clk),
		.i_srst(i_srst), .i_set_select_high(sel), .i_min_transition_delay_setting(tzmin),
		.i_line_sense_ua(line), .i_switch_node_at_zvs(zvs), .i_aux_zero_cross_event(zc),
		.i_peak_current_trip(trip), .i_peak_current_threshold(thr), .i_opp_level(lvl),
		.i_load_down(dn), .i_load_up(up), .i_burst_start(bst), .o_low_side_gate_pulse(lo),
		.o_high_side_gate_pulse(hi), .o_driver_enable(drv), .o_over_power_protection(over_power_protection),
		.o_mode(mode), .o_tune_settled(lock));
	acf_power_stage_model u_stage (.i_clk(i_clk), .i_low_on(lo), .i_high_on(hi),
		.i_zvs_allowed(zvs_ok), .o_trip(trip), .o_zc(zc), .o_zvs(zvs));
	initial
	begin
		forever #5 i_clk = ~i_clk;
	end
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("BAD %0t %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask
	task automatic check_rng(input int got, input int lo_b, input int hi_b, input string m);
		check_val(32'(got >= lo_b && got <= hi_b), 32'h1, m);
	endtask
	function automatic int tz_exp(input int s, input int i);
		int b;
		b = (s == 0) ? 1 : s;
		return (i < `LINE_KNEE_UA) ? b + b * (`LINE_KNEE_UA - i) * `TZ_EXT_PCT / 66600 : b;
	endfunction
	task automatic wait_gate(input bit s, input logic v, output int c);
		c = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			c++;
		end
		while ((s ? hi : lo) !== v && c < 20000);
	endtask
	task automatic count_lows(input int win, output int c);
		logic p;
		c = 0;
		p = lo;
		repeat (win)
		begin
			@(posedge i_clk);
			#1;
			c += int'(lo && !p);
			p = lo;
		end
	endtask
	task automatic pulse_in(input int which);
		@(posedge i_clk);
		dn <= which == 0;
		up <= which == 1;
		bst <= which == 2;
		@(posedge i_clk);
		{dn, up, bst} <= 3'h0;
	endtask
	task automatic step(input int which, input logic [1:0] exp);
		pulse_in(which);
		repeat (300) @(posedge i_clk);
		#1;
		check_val(mode, exp, "mode step");
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			miscompares++;
			wrap_up();
		end
	end
	initial
	begin
		void'($urandom(74360));
		repeat (3) @(posedge i_clk);
		i_srst <= 1'b0;
		lvl <= 8'($urandom_range(240, 32));
		#1;
		check_val({lo, hi, drv, over_power_protection, mode}, 6'h00, "reset outputs");
		n = 0;
		while (lock !== 1'b1 && n < 40)
		begin
			wait_gate(0, 1, g);
			wait_gate(0, 0, g);
			n++;
		end
		check_rng(n, 1, 16, "settle cycles");
		check_val(drv, 1'b1, "driver enable");
		foreach (lines[k])
		begin
			@(posedge i_clk);
			tzmin <= 8'($urandom_range(6, 2));
			line <= 10'(lines[k]);
			wait_gate(1, 1, g);
			wait_gate(1, 0, g);
			wait_gate(0, 1, g);
			check_val(g, tz_exp(tzmin, lines[k]), "hl dead");
			wait_gate(0, 0, g);
			wait_gate(1, 1, g);
			check_val(g, `LH_DEAD_FIXED_CYC, "lh dead");
		end
		// comparator stuck: each cycle must lengthen the next high pulse
		@(posedge i_clk);
		zvs_ok <= 1'b0;
		wait_gate(1, 0, g);
		wait_gate(1, 1, g);
		wait_gate(1, 0, w);
		wait_gate(1, 1, g);
		wait_gate(1, 0, n);
		check_val(n, w + 1, "tune lengthen");
		zvs_ok <= 1'b1;
		// select only moves inside a low pulse, never during a dead-time
		wait_gate(0, 1, g);
		@(posedge i_clk);
		sel <= 1'b1;
		repeat (2000) @(posedge i_clk);
		wait_gate(0, 0, g);
		wait_gate(0, 1, g);
		@(posedge i_clk);
		sel <= 1'b0;
		step(0, 2'h1);
		// packet inherited from amplitude mode must run out first
		n = 0;
		while (drv !== 1'b0 && n < 3000)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		check_val(drv, 1'b0, "burst gap driver off");
		repeat (3)
		begin
			pulse_in(2);
			count_lows(2500, n);
			check_rng(n, 2, 9, "burst packet");
		end
		step(0, 2'h3);
		wait_gate(0, 1, g);
		count_lows(3990, n);
		check_val(n, 1, "low-power packet");
		wait_gate(0, 1, g);
		check_rng(g, 1, 20, "low-power period");
		step(0, 2'h2);
		count_lows(6000, n);
		check_val(n, 0, "standby idle");
		pulse_in(2);
		count_lows(500, n);
		check_val(n, 2, "standby packet");
		step(1, 2'h3);
		step(1, 2'h1);
		step(1, 2'h0);
		check_val(drv, 1'b1, "driver enable back");
		@(posedge i_clk);
		thr <= lvl;
		repeat (20) @(posedge i_clk);
		thr <= 8'h10;
		#1;
		check_val(over_power_protection, 1'b0, "short overload");
		@(posedge i_clk);
		thr <= 8'($urandom_range(255, int'(lvl)));
		repeat (OPP_CYC - 5) @(posedge i_clk);
		#1;
		check_val(over_power_protection, 1'b0, "fault early");
		repeat (10) @(posedge i_clk);
		#1;
		check_val({over_power_protection, lo, hi, drv}, 4'h8, "fault blank");
		wrap_up();
	end
endmodule

// ---- verilog/acf_zvs_mode_pwm_control.sv ----
/*
 switching controller: gate pulses, dead-times, on-time tuning, load modes, over-power timer.
 assumes comparator events synchronous to i_clk, one-cycle load step pulses from the loop.
*/
// What this block does
// - zvs not reached by end of tz wait: lengthen high-side on-time next cycle
// - tuning settles within 15 cycles, then toggles on-time by one lsb
// - valley-switching used until the tuning loop has settled
// - tz starts at minimum, grows linearly below 666 uA, up to 140 percent
// - select low: low-to-high dead-time fixed at about 40 ns
// - select high: wait aux zero-cross after low pulse, high pulse 50 ns later
// - amplitude mode: complementary pulses with dead-time and tuning active
// - burst mode: packets of pulses, off-time between packets regulates output
// - burst mode: pulses per packet adjusted to keep burst rate above 20 kHz
// - low-power and standby: high-side pulse and tuning disabled, valley only
// - low-power: burst rate fixed near 25 kHz
// - standby: burst rate may fall below 25 kHz
// - amplitude mode: negative current constant, peak threshold lowered with load upstream
// - peak threshold at over-power level for 160 ms raises the fault
// - amplitude mode: driver enable held high continuously until the over-power fault blanks it
`include "acf_pwm_regs.svh"
module acf_zvs_mode_pwm_control #(
	parameter int OPP_TIMEOUT_CYC = `OPP_TIMEOUT_CYC
)(
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_set_select_high,
	input wire logic [7:0] i_min_transition_delay_setting,
	input wire logic [9:0] i_line_sense_ua,
	input wire logic i_switch_node_at_zvs,
	input wire logic i_aux_zero_cross_event,
	input wire logic i_peak_current_trip,
	input wire logic [7:0] i_peak_current_threshold,
	input wire logic [7:0] i_opp_level,
	input wire logic i_load_down,
	input wire logic i_load_up,
	input wire logic i_burst_start,
	output logic o_low_side_gate_pulse,
	output logic o_high_side_gate_pulse,
	output logic o_driver_enable,
	output logic o_over_power_protection,
	output logic [1:0] o_mode,
	output logic o_tune_settled
);
	localparam logic [15:0] LPM_PERIOD = 16'(`LPM_PERIOD_CYC);
	localparam logic [15:0] BUR_MAX_PERIOD = 16'(`BUR_MIN_PERIOD_CYC);
	localparam logic [15:0] LH_FIXED = 16'(`LH_DEAD_FIXED_CYC);
	localparam logic [15:0] ZC_DLY = 16'(`ZC_TO_HS_CYC);

	acf_pwm_pkg::mode_t mode_r;
	acf_pwm_pkg::phase_t ph_r;
	logic [15:0] ph_cnt_r;
	logic [7:0] tdm_r;
	logic [3:0] settle_cnt_r;
	logic settled_r;
	logic lsb_dir_r;
	logic zvs_seen_r;
	logic zc_seen_r;
	logic [3:0] nsw_r;
	logic [3:0] pulse_cnt_r;
	logic [15:0] bur_cnt_r;
	logic in_packet_r;
	logic [27:0] opp_cnt_r;
	logic [15:0] tz_cyc;
	logic [15:0] tz_ext;
	logic hs_enable;
	logic tune_enable;

	// line below knee stretches tz linearly, reaching 140 percent extra at zero line
	always_comb
	begin
		tz_ext = 16'h0000;
		if (i_line_sense_ua < 10'(`LINE_KNEE_UA))
		begin
			tz_ext = 16'((32'(10'(`LINE_KNEE_UA) - i_line_sense_ua)
				* 32'(i_min_transition_delay_setting) * 32'(`TZ_EXT_PCT))
				/ (32'(`LINE_KNEE_UA) * 32'd100));
		end
		tz_cyc = 16'(i_min_transition_delay_setting) + tz_ext;
		if (tz_cyc == 16'h0000)
			tz_cyc = 16'h0001;
	end

	// high side only where zvs applies and tuning has locked
	assign tune_enable = (mode_r == acf_pwm_pkg::amplitude_mod_mode)
		|| (mode_r == acf_pwm_pkg::adaptive_burst_state);
	assign hs_enable = tune_enable && settled_r;

	// mode stepping, one step per load event
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			mode_r <= acf_pwm_pkg::amplitude_mod_mode;
		else if (i_load_down)
		begin
			case (mode_r)
				acf_pwm_pkg::amplitude_mod_mode: mode_r <= acf_pwm_pkg::adaptive_burst_state;
				acf_pwm_pkg::adaptive_burst_state: mode_r <= acf_pwm_pkg::low_power_state;
				acf_pwm_pkg::low_power_state: mode_r <= acf_pwm_pkg::standby_state;
				default: mode_r <= mode_r;
			endcase
		end
		else if (i_load_up)
		begin
			case (mode_r)
				acf_pwm_pkg::standby_state: mode_r <= acf_pwm_pkg::low_power_state;
				acf_pwm_pkg::low_power_state: mode_r <= acf_pwm_pkg::adaptive_burst_state;
				acf_pwm_pkg::adaptive_burst_state: mode_r <= acf_pwm_pkg::amplitude_mod_mode;
				default: mode_r <= mode_r;
			endcase
		end
	end

	// burst timing: packet start requests come from the output loop, except in low-power where the period counter starts packets
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			bur_cnt_r <= 16'h0000;
			in_packet_r <= 1'b0;
			nsw_r <= `NSW_MAX;
		end
		else
		begin
			if (bur_cnt_r != 16'hffff)
				bur_cnt_r <= bur_cnt_r + 16'h0001;
			if (mode_r == acf_pwm_pkg::amplitude_mod_mode)
				in_packet_r <= 1'b1;
			else if (!in_packet_r)
			begin
				// counter restarts at zero on the start edge, so compare one short
				if ((mode_r == acf_pwm_pkg::low_power_state
					&& bur_cnt_r >= LPM_PERIOD - 16'h0001)
					|| (mode_r != acf_pwm_pkg::low_power_state && i_burst_start))
				begin
					in_packet_r <= 1'b1;
					bur_cnt_r <= 16'h0000;
					// period too long means rate under 20 kHz: fewer pulses
					if (mode_r == acf_pwm_pkg::adaptive_burst_state)
					begin
						if (bur_cnt_r > BUR_MAX_PERIOD && nsw_r > `NSW_MIN)
							nsw_r <= nsw_r - 4'h1;
						else if (bur_cnt_r <= BUR_MAX_PERIOD && nsw_r < `NSW_MAX)
							nsw_r <= nsw_r + 4'h1;
					end
					else
						nsw_r <= `NSW_MIN;
				end
			end
			// packet ends with its last cycle, valley or zvs, else idle restarts it
			else if (pulse_cnt_r >= nsw_r
				&& ((ph_r == acf_pwm_pkg::ph_valley && i_aux_zero_cross_event)
				|| (ph_r == acf_pwm_pkg::ph_hl_dead && ph_cnt_r + 16'h0001 >= tz_cyc)))
				in_packet_r <= 1'b0;
		end
	end

	// switching sequence
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ph_r <= acf_pwm_pkg::ph_idle;
			ph_cnt_r <= 16'h0000;
			pulse_cnt_r <= 4'h0;
			zvs_seen_r <= 1'b0;
			zc_seen_r <= 1'b0;
		end
		else
		begin
			ph_cnt_r <= ph_cnt_r + 16'h0001;
			case (ph_r)
				acf_pwm_pkg::ph_idle:
				begin
					pulse_cnt_r <= 4'h0;
					if (in_packet_r)
					begin
						ph_r <= acf_pwm_pkg::ph_low;
						ph_cnt_r <= 16'h0000;
					end
				end
				acf_pwm_pkg::ph_low:
				begin
					// peak current trip ends the low pulse; threshold is lowered upstream
					if (i_peak_current_trip)
					begin
						pulse_cnt_r <= pulse_cnt_r + 4'h1;
						ph_cnt_r <= 16'h0000;
						zc_seen_r <= 1'b0;
						ph_r <= hs_enable ? acf_pwm_pkg::ph_lh_dead : acf_pwm_pkg::ph_valley;
					end
				end
				acf_pwm_pkg::ph_lh_dead:
				begin
					if (!i_set_select_high)
					begin
						if (ph_cnt_r + 16'h0001 >= LH_FIXED)
						begin
							ph_r <= acf_pwm_pkg::ph_high;
							ph_cnt_r <= 16'h0000;
						end
					end
					else if (!zc_seen_r)
					begin
						if (i_aux_zero_cross_event)
						begin
							zc_seen_r <= 1'b1;
							ph_cnt_r <= 16'h0000;
						end
					end
					else if (ph_cnt_r + 16'h0001 >= ZC_DLY)
					begin
						ph_r <= acf_pwm_pkg::ph_high;
						ph_cnt_r <= 16'h0000;
					end
				end
				acf_pwm_pkg::ph_high:
				begin
					if (ph_cnt_r + 16'h0001 >= 16'(tdm_r))
					begin
						ph_r <= acf_pwm_pkg::ph_hl_dead;
						ph_cnt_r <= 16'h0000;
						zvs_seen_r <= 1'b0;
					end
				end
				acf_pwm_pkg::ph_hl_dead:
				begin
					if (i_switch_node_at_zvs)
						zvs_seen_r <= 1'b1;
					if (ph_cnt_r + 16'h0001 >= tz_cyc)
					begin
						ph_cnt_r <= 16'h0000;
						ph_r <= (in_packet_r && (mode_r == acf_pwm_pkg::amplitude_mod_mode
							|| pulse_cnt_r < nsw_r)) ? acf_pwm_pkg::ph_low
							: acf_pwm_pkg::ph_idle;
					end
				end
				acf_pwm_pkg::ph_valley:
				begin
					// valley turn-on at the next zero crossing
					if (i_aux_zero_cross_event)
					begin
						ph_cnt_r <= 16'h0000;
						ph_r <= (in_packet_r && (mode_r == acf_pwm_pkg::amplitude_mod_mode
							|| pulse_cnt_r < nsw_r)) ? acf_pwm_pkg::ph_low
							: acf_pwm_pkg::ph_idle;
					end
				end
				default: ph_r <= acf_pwm_pkg::ph_idle;
			endcase
		end
	end

	// on-time tuning; also runs in valley cycles so it can reach lock
	always_ff @(posedge i_clk)
	begin
		if (i_srst || !tune_enable)
		begin
			tdm_r <= `TDM_INIT;
			settle_cnt_r <= 4'h0;
			settled_r <= 1'b0;
			lsb_dir_r <= 1'b0;
		end
		else if ((ph_r == acf_pwm_pkg::ph_hl_dead && ph_cnt_r + 16'h0001 >= tz_cyc)
			|| (ph_r == acf_pwm_pkg::ph_valley && i_aux_zero_cross_event))
		begin
			if (!settled_r)
			begin
				if (!zvs_seen_r || ph_r == acf_pwm_pkg::ph_valley)
				begin
					if (tdm_r < (`TDM_MAX - 8'h07))
						tdm_r <= tdm_r + 8'h08;
				end
				settle_cnt_r <= settle_cnt_r + 4'h1;
				if (settle_cnt_r == 4'(`SETTLE_CYCLES - 1)
					|| (zvs_seen_r && ph_r == acf_pwm_pkg::ph_hl_dead))
					settled_r <= 1'b1;
			end
			else
			begin
				lsb_dir_r <= !lsb_dir_r;
				if (!zvs_seen_r && tdm_r != `TDM_MAX)
					tdm_r <= tdm_r + 8'h01;
				else
					tdm_r <= lsb_dir_r ? tdm_r + 8'h01 : tdm_r - 8'h01;
			end
		end
	end

	// over-power timeout: restarts whenever threshold drops below the level
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			opp_cnt_r <= 28'h000_0000;
			o_over_power_protection <= 1'b0;
		end
		else if (i_peak_current_threshold >= i_opp_level)
		begin
			if (opp_cnt_r >= 28'(OPP_TIMEOUT_CYC - 1))
				o_over_power_protection <= 1'b1;
			else
				opp_cnt_r <= opp_cnt_r + 28'h000_0001;
		end
		else
			opp_cnt_r <= 28'h000_0000;
	end

	// registered outputs
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_low_side_gate_pulse <= 1'b0;
			o_high_side_gate_pulse <= 1'b0;
			o_driver_enable <= 1'b0;
			o_mode <= 2'b00;
			o_tune_settled <= 1'b0;
		end
		else
		begin
			o_low_side_gate_pulse <= (ph_r == acf_pwm_pkg::ph_low) && !o_over_power_protection;
			o_high_side_gate_pulse <= (ph_r == acf_pwm_pkg::ph_high) && hs_enable
				&& !o_over_power_protection;
			o_driver_enable <= ((mode_r == acf_pwm_pkg::amplitude_mod_mode)
				|| in_packet_r || ph_r != acf_pwm_pkg::ph_idle) && !o_over_power_protection;
			o_mode <= mode_r;
			o_tune_settled <= settled_r;
		end
	end
endmodule
